// ===== rtl/eiie_pkg.sv
package eiie_pkg;
  // ==========================================================
  // opcode fields
  localparam logic [7:0] OP_ADD = 8'h00E8;
  localparam logic [7:0] OP_SUB = 8'h00E9;
  localparam logic [7:0] OP_PUSH = 8'h00EA;
  localparam logic [7:0] OP_MOVS = 8'h00EB;
  localparam logic [3:0] OP_SECOND = 4'h000F;
  localparam logic [15:0] OP_CALL_VIA_WORKING_REG = 16'h0014;
  localparam logic [1:0] SEL_RET = 2'h3;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 6;
  localparam int MOVS_KIND_BIT = 7;
  // ==========================================================
  // widths and addresses
  localparam int ADDR_W = 12;
  localparam int PC_W = 21;
  localparam logic [PC_W-1:0] PC_STEP = 21'h00_0002;
  localparam logic [6:0] ACCESS_LIMIT = 7'h5F;
  // indirect-access register window and forbidden destinations
  localparam logic [ADDR_W-1:0] IND_LO = 12'h0FDB;
  localparam logic [ADDR_W-1:0] IND_HI = 12'h0FEF;
  localparam logic [ADDR_W-1:0] PCL_ADDR = 12'h0FF9;
  localparam logic [ADDR_W-1:0] TOS_LO = 12'h0FFD;
  localparam logic [ADDR_W-1:0] TOS_HI = 12'h0FFF;
  localparam logic [7:0] ZERO_BYTE = 8'h0000;
  localparam logic EXT_ENABLE_UNPROG = 1'b1;
  // ==========================================================
  // states
  typedef enum logic [1:0] {
    EIIE_FETCH,
    EIIE_FLUSH,
    EIIE_MOVE2
  } eiie_state_t;
endpackage : eiie_pkg

// ===== rtl/eiie_core.sv
`timescale 1ns/10ps
// Summary of operation
// RULE1: extension on unless config bit programmed off
// RULE2: pointer add literal, one cycle, flags kept
// RULE3: select 11 means pointer two return variant
// RULE4: add to pointer two, return, two cycles
// RULE5: second cycle discards the fetched word
// RULE6: pointer subtract literal, one cycle, flags kept
// RULE7: select 11 subtract then return, two cycles
// RULE8: fixed word decodes call via working register
// RULE9: push pc plus two, load pc from latches
// RULE10: indexed to absolute move, two words
// RULE11: indexed to indexed move, two words
// RULE12: push literal at pointer two, decrement
// RULE13: source pointer two plus offset, indirect zero
// RULE14: indirect indexed destination makes a no-op
// RULE15: access bank low addresses use indexed offset
// RULE16: pointer arithmetic wraps at address width
module eiie_core (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // configuration
  input wire logic extension_enable_config,
  // fetch stream
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [eiie_pkg::PC_W-1:0] prog_count,
  // core state
  input wire logic [7:0] working_register,
  input wire logic [7:0] prog_count_high_latch,
  input wire logic [7:0] prog_count_upper_latch,
  input wire logic [eiie_pkg::PC_W-1:0] return_stack_top,
  input wire logic [7:0] data_rd,
  // standard instruction address mapping
  input wire logic std_access,
  input wire logic [7:0] std_file_addr,
  output logic std_indexed,
  output logic [eiie_pkg::ADDR_W-1:0] std_addr,
  // pointers
  output logic [eiie_pkg::ADDR_W-1:0] file_select_pointer [3],
  // decode
  output logic ext_hit,
  output logic discard,
  // data memory
  output logic [eiie_pkg::ADDR_W-1:0] data_addr,
  output logic data_rd_en,
  output logic data_wr_en,
  output logic [7:0] data_wr,
  // program counter control
  output logic pc_load,
  output logic [eiie_pkg::PC_W-1:0] pc_value,
  output logic stack_push,
  output logic [eiie_pkg::PC_W-1:0] stack_push_value
);
  // ==========================================================
  // helpers
  function automatic logic [eiie_pkg::ADDR_W-1:0] offs(
    input logic [eiie_pkg::ADDR_W-1:0] base,
    input logic [6:0] off
  );
    offs = base + {5'h00, off}; // RULE16
  endfunction : offs

  function automatic logic is_ind(input logic [eiie_pkg::ADDR_W-1:0] a);
    is_ind = (a >= eiie_pkg::IND_LO) && (a <= eiie_pkg::IND_HI);
  endfunction : is_ind

  function automatic logic no_dest(input logic [eiie_pkg::ADDR_W-1:0] a);
    no_dest = (a == eiie_pkg::PCL_ADDR) ||
      ((a >= eiie_pkg::TOS_LO) && (a <= eiie_pkg::TOS_HI));
  endfunction : no_dest

  // ==========================================================
  // decode
  eiie_pkg::eiie_state_t state;
  logic en;
  logic [7:0] op;
  logic [1:0] sel;
  logic [5:0] lit6;
  logic is_add, is_sub, is_push, is_movs, is_call_via_working_reg, is_ret;
  logic [eiie_pkg::ADDR_W-1:0] p2;
  logic [eiie_pkg::ADDR_W-1:0] src_addr;
  logic [7:0] src_byte;
  logic movs_kind;
  logic [eiie_pkg::ADDR_W-1:0] dst_addr;
  logic dst_ok;
  logic live;

  assign en = extension_enable_config == eiie_pkg::EXT_ENABLE_UNPROG; // RULE1
  assign live = instr_valid && en && state == eiie_pkg::EIIE_FETCH;
  assign op = instr_word[15:8];
  assign sel = instr_word[eiie_pkg::SEL_HI:eiie_pkg::SEL_LO];
  assign lit6 = instr_word[5:0];
  assign p2 = file_select_pointer[2];
  assign is_add = live && op == eiie_pkg::OP_ADD; // RULE2
  assign is_sub = live && op == eiie_pkg::OP_SUB; // RULE6
  assign is_push = live && op == eiie_pkg::OP_PUSH; // RULE12
  assign is_movs = live && op == eiie_pkg::OP_MOVS; // RULE10 RULE11
  assign is_call_via_working_reg = live && instr_word == eiie_pkg::OP_CALL_VIA_WORKING_REG; // RULE8
  assign is_ret = (is_add || is_sub) && sel == eiie_pkg::SEL_RET; // RULE3
  assign ext_hit = is_add || is_sub || is_push || is_movs || is_call_via_working_reg;
  assign discard = state == eiie_pkg::EIIE_FLUSH; // RULE5
  assign std_indexed = en && std_access &&
    std_file_addr <= {1'b0, eiie_pkg::ACCESS_LIMIT}; // RULE15
  assign std_addr = std_indexed ? offs(p2, std_file_addr[6:0]) :
    {4'h0, std_file_addr};

  // ==========================================================
  // sequencing
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= eiie_pkg::EIIE_FETCH;
    end else begin
      unique case (state)
        eiie_pkg::EIIE_FETCH: begin
          if (is_ret || is_call_via_working_reg) begin
            state <= eiie_pkg::EIIE_FLUSH; // RULE4 RULE7 RULE8
          end else if (is_movs) begin
            state <= eiie_pkg::EIIE_MOVE2;
          end
        end
        eiie_pkg::EIIE_FLUSH: state <= eiie_pkg::EIIE_FETCH;
        eiie_pkg::EIIE_MOVE2: begin
          if (instr_valid) begin
            state <= eiie_pkg::EIIE_FETCH;
          end
        end
        default: state <= eiie_pkg::EIIE_FETCH;
      endcase
    end
  end

  // source latched during first word
  always_ff @(posedge clk) begin
    if (!nrst) begin
      src_byte <= eiie_pkg::ZERO_BYTE;
      movs_kind <= 1'b0;
    end else if (is_movs) begin
      movs_kind <= instr_word[eiie_pkg::MOVS_KIND_BIT];
      src_byte <= is_ind(src_addr) ? eiie_pkg::ZERO_BYTE : data_rd; // RULE13
    end
  end
  assign src_addr = offs(p2, instr_word[6:0]); // RULE13

  // second word destination
  always_comb begin
    if (movs_kind) begin
      dst_addr = offs(p2, instr_word[6:0]); // RULE11
      dst_ok = !is_ind(dst_addr) && !no_dest(dst_addr); // RULE14 RULE13
    end else begin
      dst_addr = instr_word[eiie_pkg::ADDR_W-1:0]; // RULE10
      dst_ok = !no_dest(dst_addr); // RULE13
    end
  end

  // ==========================================================
  // pointers
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        file_select_pointer[i] <= '0;
      end
    end else if (is_ret) begin
      file_select_pointer[2] <= is_add ? p2 + {6'h00, lit6} :
        p2 - {6'h00, lit6}; // RULE4 RULE7 RULE16
    end else if (is_add) begin
      file_select_pointer[sel] <= file_select_pointer[sel] +
        {6'h00, lit6}; // RULE2 RULE16
    end else if (is_sub) begin
      file_select_pointer[sel] <= file_select_pointer[sel] -
        {6'h00, lit6}; // RULE6 RULE16
    end else if (is_push) begin
      file_select_pointer[2] <= p2 - 12'h001; // RULE12 RULE16
    end
  end

  // ==========================================================
  // data memory port
  always_comb begin
    data_addr = '0;
    data_rd_en = 1'b0;
    data_wr_en = 1'b0;
    data_wr = eiie_pkg::ZERO_BYTE;
    if (is_push) begin
      data_addr = p2; // RULE12
      data_wr_en = 1'b1;
      data_wr = instr_word[7:0];
    end else if (is_movs) begin
      data_addr = src_addr;
      data_rd_en = !is_ind(src_addr); // RULE13
    end else if (state == eiie_pkg::EIIE_MOVE2 && instr_valid) begin
      data_addr = dst_addr;
      data_wr_en = dst_ok && instr_word[15:12] == eiie_pkg::OP_SECOND;
      data_wr = src_byte;
    end
  end

  // ==========================================================
  // program counter
  always_comb begin
    pc_load = 1'b0;
    pc_value = '0;
    stack_push = 1'b0;
    stack_push_value = '0;
    if (is_ret) begin
      pc_load = 1'b1;
      pc_value = return_stack_top; // RULE4 RULE7
    end else if (is_call_via_working_reg) begin
      stack_push = 1'b1;
      stack_push_value = prog_count + eiie_pkg::PC_STEP; // RULE9
      pc_load = 1'b1;
      pc_value = {prog_count_upper_latch[4:0], prog_count_high_latch,
        working_register}; // RULE9
    end
  end

  // ==========================================================
  // checks
  property p_ret_flush;
    @(posedge clk) disable iff (!nrst) is_ret |=> discard ##1 !discard;
  endproperty
  a_ret_flush: assert property (p_ret_flush) else $error("no flush"); // RULE5

  property p_push_dec;
    @(posedge clk) disable iff (!nrst)
      is_push |=> file_select_pointer[2] == $past(p2) - 12'h001;
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push"); // RULE12

  property p_add;
    @(posedge clk) disable iff (!nrst) (is_add && !is_ret && sel == 2'h0)
      |=> file_select_pointer[0] == $past(file_select_pointer[0])
      + {6'h00, $past(lit6)};
  endproperty
  a_add: assert property (p_add) else $error("add"); // RULE2

  property p_ret_pc;
    @(posedge clk) disable iff (!nrst)
      is_ret |-> pc_load && pc_value == return_stack_top;
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("ret pc"); // RULE4

  property p_off;
    @(posedge clk) disable iff (!nrst) !en |-> !ext_hit && !std_indexed;
  endproperty
  a_off: assert property (p_off) else $error("disabled hit"); // RULE1

  property p_call_via_working_reg;
    @(posedge clk) disable iff (!nrst) is_call_via_working_reg |->
      stack_push_value == prog_count + eiie_pkg::PC_STEP ##1 discard;
  endproperty
  a_call_via_working_reg: assert property (p_call_via_working_reg) else $error("call_via_working_reg"); // RULE9

  property p_movs_two;
    @(posedge clk) disable iff (!nrst) is_movs |=> state ==
      eiie_pkg::EIIE_MOVE2 && !ext_hit;
  endproperty
  a_movs_two: assert property (p_movs_two) else $error("movs"); // RULE10

  property p_noind;
    @(posedge clk) disable iff (!nrst)
      (data_wr_en && state == eiie_pkg::EIIE_MOVE2 && movs_kind)
      |-> !is_ind(data_addr);
  endproperty
  a_noind: assert property (p_noind) else $error("ind write"); // RULE14

  property p_sub;
    @(posedge clk) disable iff (!nrst) (is_sub && !is_ret && sel == 2'h1)
      |=> file_select_pointer[1] == $past(file_select_pointer[1])
      - {6'h00, $past(lit6)};
  endproperty
  a_sub: assert property (p_sub) else $error("sub"); // RULE6

  property p_sub_ret;
    @(posedge clk) disable iff (!nrst) (is_sub && is_ret)
      |=> file_select_pointer[2] == $past(p2) - {6'h00, $past(lit6)};
  endproperty
  a_sub_ret: assert property (p_sub_ret) else $error("sub ret"); // RULE7

  property p_call_via_working_reg_pc;
    @(posedge clk) disable iff (!nrst) is_call_via_working_reg |-> stack_push && pc_load &&
      pc_value[7:0] == working_register &&
      pc_value[15:8] == prog_count_high_latch;
  endproperty
  a_call_via_working_reg_pc: assert property (p_call_via_working_reg_pc) else $error("call_via_working_reg pc"); // RULE9

  property p_movs_src;
    @(posedge clk) disable iff (!nrst)
      is_movs |-> data_addr == offs(p2, instr_word[6:0]) && !data_wr_en;
  endproperty
  a_movs_src: assert property (p_movs_src) else $error("movs src"); // RULE13

  property p_push_mem;
    @(posedge clk) disable iff (!nrst) is_push |->
      data_wr_en && data_addr == p2 && data_wr == instr_word[7:0];
  endproperty
  a_push_mem: assert property (p_push_mem) else $error("push mem"); // RULE12

  property p_flush_nop;
    @(posedge clk) disable iff (!nrst)
      discard |-> !ext_hit && !pc_load && !stack_push && !data_wr_en;
  endproperty
  a_flush_nop: assert property (p_flush_nop) else $error("flush"); // RULE5

  c_ret: cover property (@(posedge clk) is_ret);
  c_call_via_working_reg: cover property (@(posedge clk) is_call_via_working_reg);
  c_movs: cover property (@(posedge clk) is_movs ##1 data_wr_en);
  c_push: cover property (@(posedge clk) is_push);
  c_sub_ret: cover property (@(posedge clk) is_sub && is_ret);
endmodule : eiie_core

// ===== verification/eiie_mem_model.sv
`timescale 1ns/10ps
// ==========================================================
// data memory read side
module eiie_mem_model (
  // clock
  input wire logic clk,
  // memory port
  input wire logic [11:0] data_addr,
  input wire logic data_rd_en,
  output logic [7:0] data_rd
);
  logic [7:0] last = 8'hA5;
  always_ff @(posedge clk) begin
    last <= data_rd;
  end
  // unselected reads show a scrambled byte, never the old one
  always_comb begin
    data_rd = data_rd_en ? (data_addr[7:0] ^ 8'h5A) : ~last;
  end
endmodule : eiie_mem_model

// ===== verification/extended_indexed_instr_exec_tb.sv
`timescale 1ns/10ps
module extended_indexed_instr_exec_tb;
  // ==========================================================
  // signals
  logic clk, nrst, extension_enable_config, instr_valid, std_access;
  logic std_indexed, ext_hit, discard, data_rd_en, data_wr_en;
  logic pc_load, stack_push;
  logic [15:0] instr_word;
  logic [20:0] prog_count, return_stack_top, pc_value, stack_push_value;
  logic [7:0] working_register, prog_count_high_latch, b;
  logic [7:0] prog_count_upper_latch, data_rd, std_file_addr, data_wr;
  logic [11:0] std_addr, data_addr, file_select_pointer [3], p [3], d;
  logic [6:0] z;
  logic [5:0] k;
  logic [1:0] f;
  integer seed, n_errors, compares, i;
  eiie_core DUT (.clk, .nrst, .extension_enable_config, .instr_valid,
    .instr_word, .prog_count, .working_register, .prog_count_high_latch,
    .prog_count_upper_latch, .return_stack_top, .data_rd, .std_access,
    .std_file_addr, .std_indexed, .std_addr, .file_select_pointer,
    .ext_hit, .discard, .data_addr, .data_rd_en, .data_wr_en, .data_wr,
    .pc_load, .pc_value, .stack_push, .stack_push_value);
  eiie_mem_model mem (.clk, .data_addr, .data_rd_en, .data_rd);
  // ==========================================================
  // helpers
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task report_and_stop;
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task chk(input logic [20:0] seen, input logic [20:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [11:0] arith(input logic [11:0] a,
      input logic [5:0] lit, input logic sub);
    return sub ? a - 12'(lit) : a + 12'(lit);
  endfunction : arith
  task do_reset(input int n);
    @(posedge clk);
    nrst <= 1'b0;
    instr_valid <= 1'b0;
    repeat (n) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    p = '{default: 12'h000};
  endtask : do_reset
  task step(input logic [15:0] w);
    @(posedge clk);
    instr_word <= w;
    instr_valid <= 1'b1;
    prog_count <= 21'($random(seed)) & 21'h1F_FFFE;
    working_register <= 8'($random(seed));
    prog_count_high_latch <= 8'($random(seed));
    prog_count_upper_latch <= 8'($random(seed));
    return_stack_top <= 21'($random(seed));
    @(negedge clk);
  endtask : step
  task idle;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
  endtask : idle
  task ptrs;
    for (int j = 0; j < 3; j++) chk(file_select_pointer[j], p[j]);
  endtask : ptrs
  task move(input logic [15:0] w1, input logic [15:0] w2,
      input logic [11:0] dst, input logic wr, input logic [7:0] v,
      input logic rd);
    step(w1);
    chk(data_rd_en, rd);
    step(w2);
    chk(data_wr_en, wr);
    if (wr) chk({data_addr, data_wr}, {dst, v});
    idle;
  endtask : move
  // ==========================================================
  // watchdog
  initial begin
    #100000;
    n_errors++;
    report_and_stop;
  end
  // ==========================================================
  // scenarios
  initial begin
    seed = 89228;
    n_errors = 0;
    compares = 0;
    {nrst, extension_enable_config, instr_valid, std_access} = 4'b0100;
    {instr_word, prog_count, return_stack_top} = '0;
    {working_register, prog_count_high_latch} = '0;
    {prog_count_upper_latch, std_file_addr} = '0;
    do_reset(20);
    ptrs;
    // pointer arithmetic, wrap below zero first
    for (i = 0; i < 40; i++) begin
      f = (i < 2) ? 2'd2 : 2'($unsigned($random(seed)) % 3);
      k = (i < 2) ? 6'h3F : 6'($random(seed));
      step({7'b1110_100, ~i[0], f, k});
      chk({ext_hit, pc_load}, 2'b10);
      p[f] = arith(p[f], k, ~i[0]);
      idle;
      ptrs;
    end
    // add and subtract with return, flushed word behind
    for (i = 0; i < 2; i++) begin
      k = 6'($random(seed));
      step({7'b1110_100, i[0], 2'b11, k});
      chk(pc_load, 1'b1);
      chk(pc_value, return_stack_top);
      p[2] = arith(p[2], k, i[0]);
      step(16'h0014);
      chk({discard, stack_push}, 2'b10);
      idle;
      ptrs;
    end
    // call through working register
    step(16'h0014);
    chk(stack_push_value, prog_count + 21'h00_0002);
    chk(pc_value, {prog_count_upper_latch[4:0], prog_count_high_latch,
      working_register});
    chk({stack_push, pc_load}, 2'b11);
    idle;
    chk(discard, 1'b1);
    // literal push onto soft stack
    b = 8'($random(seed));
    step({8'hEA, b});
    chk({data_wr_en, data_addr, data_wr}, {1'b1, p[2], b});
    p[2] = p[2] - 12'h001;
    idle;
    ptrs;
    // extension switched off
    @(posedge clk);
    extension_enable_config <= 1'b0;
    step(16'hE805);
    chk(ext_hit, 1'b0);
    idle;
    ptrs;
    @(posedge clk);
    extension_enable_config <= 1'b1;
    // access bank boundary
    @(posedge clk);
    std_access <= 1'b1;
    std_file_addr <= 8'h5F;
    @(negedge clk);
    chk({std_indexed, std_addr}, {1'b1, p[2] + 12'h05F});
    @(posedge clk);
    std_file_addr <= 8'h60;
    @(negedge clk);
    chk(std_indexed, 1'b0);
    chk(std_addr, 12'h060);
    @(posedge clk);
    std_access <= 1'b0;
    std_file_addr <= 8'h20;
    @(negedge clk);
    chk({std_indexed, std_addr}, {1'b0, 12'h020});
    // indexed moves from a known pointer, second reset first
    do_reset(2);
    z = 7'($random(seed));
    d = 12'($random(seed)) & 12'h07FF;
    move({9'b1110_1011_0, z}, {4'hF, d}, d, 1'b1, {1'b0, z} ^ 8'h5A, 1'b1);
    k = 6'($random(seed));
    move({9'b1110_1011_1, z}, {9'b1111_0000_0, k[5:0], 1'b1},
      {5'h00, k, 1'b1}, 1'b1, {1'b0, z} ^ 8'h5A, 1'b1);
    step(16'hE9BF);
    step(16'hE89A);
    idle;
    p[2] = 12'h0FDB;
    ptrs;
    move(16'hEB80, 16'hF000, 12'h000, 1'b0, 8'h00, 1'b0);
    move(16'hEB00, 16'hF100, 12'h100, 1'b1, 8'h00, 1'b0);
    report_and_stop;
  end
endmodule : extended_indexed_instr_exec_tb
